/* File: rtl/stp_pkg.sv */
// Shared constants and types of the two-channel stepper profile engine.
// Assumes a 200 MHz module clock and an Avalon-MM host with 32-bit data.
package stp_pkg;
   localparam int unsigned CLK_HZ_INT = 200000000;
   localparam logic [27:0] CLK_HZ = 28'(CLK_HZ_INT);
   localparam int unsigned NUM_CH = 2;
   // Command codes; bit 0 selects motor B, except in the mask and ack codes.
   localparam logic [15:0] CMD_MASK_IRQ = 16'h0020;
   localparam logic [15:0] CMD_IRQ_ACK = 16'h0030;
   localparam logic [14:0] CMD_ABS_MOVE = 15'h0180;
   localparam logic [14:0] CMD_OFF_MOVE = 15'h0200;
   localparam logic [14:0] CMD_GET_POS = 15'h0280;
   localparam logic [14:0] CMD_SET_POS = 15'h0300;
   localparam logic [14:0] CMD_FIX_BRK = 15'h0380;
   localparam logic [14:0] CMD_OFF_BRK = 15'h0400;
   localparam logic [14:0] CMD_ABORT = 15'h0780;
   // Result codes.
   localparam logic [15:0] RES_OK = 16'h0000;
   localparam logic [15:0] RES_RANGE = 16'h0001;
   localparam logic [15:0] RES_RAMP = 16'h0002;
   localparam logic [15:0] RES_INVALID = 16'h0003;
   // Profile limits.
   localparam logic [31:0] RISE_MIN_HZ = 32'd15;
   localparam logic [31:0] DRIVE_MAX_HZ = 32'd50000;
   localparam logic [31:0] ACC_MIN = 32'd50;
   localparam logic [31:0] ACC_MAX = 32'd5000000;
   localparam logic [63:0] RAMP_MAX_PLS = 64'd5000;
   localparam logic [15:0] DUAL_MAX_HZ = 16'd20000;
   // Interrupt status bits.
   localparam int unsigned IRQ_BRK_BIT = 1;
   localparam int unsigned IRQ_DONE_BIT = 3;
   localparam logic [7:0] IRQ_RESET = 8'h00;
   // Register byte offsets.
   localparam logic [7:0] REG_CMD = 8'h00;
   localparam logic [7:0] REG_PARAM0 = 8'h04;
   localparam logic [7:0] REG_PARAM7 = 8'h20;
   localparam logic [7:0] REG_RESULT = 8'h24;
   localparam logic [7:0] REG_OUTPOS = 8'h28;
   localparam logic [7:0] REG_IRQ_STAT = 8'h2c;
   localparam logic [7:0] REG_IRQ_MASK = 8'h30;
   localparam logic [7:0] REG_POS_A = 8'h34;
   localparam logic [7:0] REG_POS_B = 8'h38;
   localparam logic [7:0] REG_MOTION = 8'h3c;

   typedef enum logic [1:0] {ST_IDLE, ST_ACCEL, ST_CRUISE, ST_DECEL} stp_mstate_t;

   typedef struct packed {
      stp_mstate_t st;
      logic dir;
      logic step;
      logic [31:0] pos;
      logic [31:0] remain;
      logic [15:0] ramp;
      logic [15:0] freq;
      logic [15:0] rise;
      logic [15:0] drive;
      logic [22:0] accel;
      logic [27:0] vacc;
      logic [27:0] phase;
      logic [31:0] bp;
      logic bp_en;
      logic pend;
      logic [31:0] pend_tgt;
   } stp_ch_t;
endpackage

/* File: rtl/stp_engine.sv */
// Two-channel trapezoidal stepper engine with an Avalon-MM command register set.
// Assumes synchronous inputs on clk_i and a host writing one command at a time.
//
// How it works
// - Codes 0x0300/0x0301 start an absolute trapezoidal move on motor A or B.
// - Reject rise frequency below 15 Hz or above the drive frequency.
// - Reject drive frequency below rise frequency or above 50000 Hz.
// - Reject acceleration below 50 Hz/s or above 5000000 Hz/s.
// - Any out-of-range parameter returns the range error and starts nothing.
// - Each channel keeps a signed 32-bit position, zero after reset.
// - Absolute move steps are target minus position; sign gives direction.
// - Motion commands finish once the profile starts; new commands accepted while moving.
// - A finished profile sets the channel's move-done flag.
// - Same-direction absolute target during motion only moves the end point.
// - Opposite-direction target aborts the move and starts a reverse profile.
// - Ramp length over 5000 pulses returns the ramp error.
// - Codes 0x0400/0x0401 move by a signed offset; sign gives direction.
// - Codes 0x0500/1 read position; 0x0600/1 load position.
// - Codes 0x0700/1 arm an absolute breakpoint; equal position sets the flag.
// - Resting on the breakpoint raises the flag only once.
// - Codes 0x0800/1 arm a breakpoint at position plus offset.
// - Abort codes 0x0f00/1 send the active profile into deceleration.
// - One motor may step at 50 kHz; two together are held to 20 kHz in acceleration and cruise.
// - Breakpoints update status; interrupt requested only where the mask enables.
// - Status bits: breakpoint A 0x02, B 0x04, done A 0x08, B 0x10.
//
// The Avalon-MM slave port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
module stp_engine (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic [7:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   output logic [stp_pkg::NUM_CH-1:0] step_o,
   output logic [stp_pkg::NUM_CH-1:0] dir_o,
   output logic irq_o
);
   import stp_pkg::*;

   typedef struct packed {
      stp_ch_t [NUM_CH-1:0] ch;
      logic [7:0][15:0] param;
      logic [15:0] cmd;
      logic [15:0] result;
      logic [31:0] outpos;
      logic [7:0] irq_stat;
      logic [7:0] irq_mask;
      logic ack;
      logic [31:0] rdata;
   } stp_state_t;

   stp_state_t s_r;
   stp_state_t s_nxt;
   logic [1:0] rst_sync_r;
   logic rst_n;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rst_sync_r <= 2'b00;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_r[1];

   // Checks a profile and returns the result code it deserves.
   function automatic logic [15:0] f_check(logic [31:0] rise, logic [31:0] drv,
                                           logic [31:0] acc);
      logic [63:0] lhs;
      logic [63:0] rhs;
      lhs = 64'(drv) * 64'(drv) - 64'(rise) * 64'(rise);
      rhs = 64'(acc) * (RAMP_MAX_PLS << 1);
      if (rise < RISE_MIN_HZ || rise > drv) begin
         return RES_RANGE;
      end else if (drv > DRIVE_MAX_HZ) begin
         return RES_RANGE;
      end else if (acc < ACC_MIN || acc > ACC_MAX) begin
         return RES_RANGE;
      end else if (lhs > rhs) begin
         return RES_RAMP;
      end else begin
         return RES_OK;
      end
   endfunction

   // Tells whether a byte address falls on one of the parameter words.
   function automatic logic f_is_param(logic [7:0] a);
      return a >= REG_PARAM0 && a <= REG_PARAM7 + 8'h03;
   endfunction

   // Index of the parameter word at a byte address.
   function automatic logic [2:0] f_param_idx(logic [7:0] a);
      return 3'((a - REG_PARAM0) >> 2);
   endfunction

   // Magnitude of a signed step distance.
   function automatic logic [31:0] f_mag(logic [32:0] d);
      logic [32:0] m;
      m = d[32] ? 33'(-d) : d;
      return m[31:0];
   endfunction

   // Sends a channel into deceleration, cutting the steps left to those already ramped.
   function automatic stp_ch_t f_to_decel(stp_ch_t c);
      stp_ch_t r;
      r = c;
      r.st = ST_DECEL;
      r.pend = 1'b0;
      if (c.remain > 32'(c.ramp)) begin
         r.remain = 32'(c.ramp);
      end
      return r;
   endfunction

   // Starts a fresh profile over a signed step distance.
   function automatic stp_ch_t f_start(stp_ch_t c, logic [32:0] d);
      stp_ch_t r;
      r = c;
      r.dir = d[32];
      r.remain = f_mag(d);
      r.freq = c.rise;
      r.vacc = '0;
      r.phase = '0;
      r.ramp = '0;
      r.pend = 1'b0;
      r.st = ST_ACCEL;
      return r;
   endfunction

   // Signed distance from the current position to a target.
   function automatic logic [32:0] f_dist(logic [31:0] tgt, logic [31:0] pos);
      return {tgt[31], tgt} - {pos[31], pos};
   endfunction

   // Merges write data into a word under the byte enables.
   function automatic logic [31:0] f_merge(logic [31:0] old, logic [31:0] wd,
                                           logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
      return r;
   endfunction

   always_comb begin
      logic [15:0] fmax;
      logic [27:0] acc_sum;
      logic [27:0] ph_sum;
      logic both;
      logic [31:0] f_rise;
      logic [31:0] f_drive;
      logic [31:0] f_acc;
      logic [31:0] f_pos;
      logic [15:0] code;
      logic [15:0] chk;
      logic [31:0] tgt;
      logic [32:0] d;
      logic [31:0] wreg;
      logic [31:0] rd;
      int unsigned c;
      fmax = '0;
      acc_sum = '0;
      ph_sum = '0;
      f_rise = '0;
      f_drive = '0;
      f_acc = '0;
      f_pos = '0;
      code = '0;
      chk = '0;
      tgt = '0;
      d = '0;
      wreg = '0;
      rd = '0;
      c = 0;
      s_nxt = s_r;
      both = (s_r.ch[0].st != ST_IDLE) && (s_r.ch[1].st != ST_IDLE);

      // Host bus: first cycle of a request latches read data, second completes it.
      s_nxt.ack = (avs_read_i || avs_write_i) && !s_r.ack;
      case (avs_address_i & 8'hfc)
         REG_CMD: rd = {16'h0000, s_r.cmd};
         REG_RESULT: rd = {16'h0000, s_r.result};
         REG_OUTPOS: rd = s_r.outpos;
         REG_IRQ_STAT: rd = {24'h000000, s_r.irq_stat};
         REG_IRQ_MASK: rd = {24'h000000, s_r.irq_mask};
         REG_POS_A: rd = s_r.ch[0].pos;
         REG_POS_B: rd = s_r.ch[1].pos;
         REG_MOTION: rd = {26'h0, s_r.ch[1].dir, s_r.ch[1].st, s_r.ch[0].dir, s_r.ch[0].st};
         default: begin
            if (f_is_param(avs_address_i)) begin
               rd = {16'h0000, s_r.param[f_param_idx(avs_address_i)]};
            end else begin
               rd = '0;
            end
         end
      endcase
      if (s_nxt.ack && avs_read_i) begin
         s_nxt.rdata = rd;
      end

      // Profile fields, most significant word first.
      f_rise = {s_r.param[0], s_r.param[1]};
      f_drive = {s_r.param[2], s_r.param[3]};
      f_acc = {s_r.param[4], s_r.param[5]};
      f_pos = {s_r.param[6], s_r.param[7]};

      // Motion engines.
      for (int i = 0; i < NUM_CH; i++) begin
         s_nxt.ch[i].step = 1'b0;
         fmax = (both && s_r.ch[i].drive > DUAL_MAX_HZ) ? DUAL_MAX_HZ : s_r.ch[i].drive;
         acc_sum = s_r.ch[i].vacc + 28'(s_r.ch[i].accel);
         case (s_r.ch[i].st)
            ST_IDLE: begin
               s_nxt.ch[i].freq = '0;
            end
            ST_ACCEL: begin
               if (acc_sum >= CLK_HZ) begin
                  s_nxt.ch[i].vacc = acc_sum - CLK_HZ;
                  s_nxt.ch[i].freq = s_r.ch[i].freq + 16'h0001;
               end else begin
                  s_nxt.ch[i].vacc = acc_sum;
               end
               if (s_r.ch[i].freq >= fmax) begin
                  s_nxt.ch[i].freq = fmax;
                  s_nxt.ch[i].st = ST_CRUISE;
               end
            end
            ST_CRUISE: begin
               s_nxt.ch[i].freq = fmax;
            end
            ST_DECEL: begin
               if (acc_sum >= CLK_HZ) begin
                  s_nxt.ch[i].vacc = acc_sum - CLK_HZ;
                  if (s_r.ch[i].freq > s_r.ch[i].rise) begin
                     s_nxt.ch[i].freq = s_r.ch[i].freq - 16'h0001;
                  end
               end else begin
                  s_nxt.ch[i].vacc = acc_sum;
               end
            end
            default: begin
               s_nxt.ch[i].st = ST_IDLE;
            end
         endcase
         if (s_r.ch[i].st != ST_IDLE) begin
            if (s_r.ch[i].remain == 32'h0) begin
               if (s_r.ch[i].pend) begin
                  s_nxt.ch[i] = f_start(s_nxt.ch[i], f_dist(s_r.ch[i].pend_tgt, s_r.ch[i].pos));
               end else begin
                  s_nxt.ch[i].st = ST_IDLE;
                  s_nxt.irq_stat[IRQ_DONE_BIT + i] = 1'b1;
               end
            end else begin
               ph_sum = s_r.ch[i].phase + 28'(s_r.ch[i].freq);
               if (ph_sum >= CLK_HZ) begin
                  s_nxt.ch[i].phase = ph_sum - CLK_HZ;
                  s_nxt.ch[i].step = 1'b1;
                  s_nxt.ch[i].remain = s_r.ch[i].remain - 32'h1;
                  s_nxt.ch[i].pos = s_r.ch[i].dir ? s_r.ch[i].pos - 32'h1
                                                  : s_r.ch[i].pos + 32'h1;
                  if (s_r.ch[i].st == ST_ACCEL) begin
                     s_nxt.ch[i].ramp = s_r.ch[i].ramp + 16'h0001;
                  end else if (s_r.ch[i].st == ST_DECEL && s_r.ch[i].ramp != 16'h0) begin
                     s_nxt.ch[i].ramp = s_r.ch[i].ramp - 16'h0001;
                  end
                  // Only a step onto the value counts, so resting there flags once.
                  if (s_r.ch[i].bp_en && s_nxt.ch[i].pos == s_r.ch[i].bp) begin
                     s_nxt.irq_stat[IRQ_BRK_BIT + i] = 1'b1;
                  end
               end else begin
                  s_nxt.ch[i].phase = ph_sum;
               end
               if ((s_r.ch[i].st == ST_ACCEL || s_r.ch[i].st == ST_CRUISE)
                   && s_r.ch[i].remain <= 32'(s_r.ch[i].ramp)) begin
                  s_nxt.ch[i].st = ST_DECEL;
               end
            end
         end
      end

      // Register writes and command execution on the completing bus cycle.
      if (s_r.ack && avs_write_i) begin
         if ((avs_address_i & 8'hfc) == REG_CMD) begin
            wreg = f_merge({16'h0000, s_r.cmd}, avs_writedata_i, avs_byteenable_i);
            code = wreg[15:0];
            s_nxt.cmd = code;
            c = 32'(code[0]);
            chk = f_check(f_rise, f_drive, f_acc);
            s_nxt.result = RES_OK;
            if (code == CMD_MASK_IRQ) begin
               s_nxt.irq_mask = s_r.param[0][7:0];
            end else if (code == CMD_IRQ_ACK) begin
               // Flags set by the engines in this same cycle survive the clear.
               s_nxt.irq_stat = (s_r.irq_stat & ~s_r.param[0][7:0])
                              | (s_nxt.irq_stat & ~s_r.irq_stat);
            end else if (code[15:1] == CMD_ABS_MOVE || code[15:1] == CMD_OFF_MOVE) begin
               if (chk != RES_OK) begin
                  s_nxt.result = chk;
               end else begin
                  tgt = (code[15:1] == CMD_ABS_MOVE) ? f_pos
                                                     : s_nxt.ch[c].pos + f_pos;
                  d = f_dist(tgt, s_nxt.ch[c].pos);
                  if (s_nxt.ch[c].st == ST_IDLE) begin
                     s_nxt.ch[c].rise = f_rise[15:0];
                     s_nxt.ch[c].drive = f_drive[15:0];
                     s_nxt.ch[c].accel = f_acc[22:0];
                     s_nxt.ch[c] = f_start(s_nxt.ch[c], d);
                  end else if (d == 33'h0 || d[32] == s_nxt.ch[c].dir) begin
                     s_nxt.ch[c].remain = f_mag(d);
                     s_nxt.ch[c].pend = 1'b0;
                  end else begin
                     s_nxt.ch[c].rise = f_rise[15:0];
                     s_nxt.ch[c].drive = f_drive[15:0];
                     s_nxt.ch[c].accel = f_acc[22:0];
                     s_nxt.ch[c] = f_to_decel(s_nxt.ch[c]);
                     s_nxt.ch[c].pend = 1'b1;
                     s_nxt.ch[c].pend_tgt = tgt;
                  end
               end
            end else if (code[15:1] == CMD_GET_POS) begin
               s_nxt.outpos = s_nxt.ch[c].pos;
            end else if (code[15:1] == CMD_SET_POS) begin
               s_nxt.ch[c].pos = f_rise;
            end else if (code[15:1] == CMD_FIX_BRK) begin
               s_nxt.ch[c].bp = f_rise;
               s_nxt.ch[c].bp_en = 1'b1;
            end else if (code[15:1] == CMD_OFF_BRK) begin
               s_nxt.ch[c].bp = s_nxt.ch[c].pos + f_rise;
               s_nxt.ch[c].bp_en = 1'b1;
            end else if (code[15:1] == CMD_ABORT) begin
               if (s_nxt.ch[c].st != ST_IDLE) begin
                  s_nxt.ch[c] = f_to_decel(s_nxt.ch[c]);
               end
            end else begin
               s_nxt.result = RES_INVALID;
            end
         end else if (f_is_param(avs_address_i)) begin
            wreg = f_merge({16'h0000, s_r.param[f_param_idx(avs_address_i)]},
                           avs_writedata_i, avs_byteenable_i);
            s_nxt.param[f_param_idx(avs_address_i)] = wreg[15:0];
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= '0;
         s_r.irq_stat <= IRQ_RESET;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !s_r.ack;
   assign avs_readdata_o = s_r.rdata;
   assign irq_o = |(s_r.irq_stat & s_r.irq_mask);
   always_comb begin
      for (int i = 0; i < NUM_CH; i++) begin
         step_o[i] = s_r.ch[i].step;
         dir_o[i] = s_r.ch[i].dir;
      end
   end
endmodule

/* File: sim/stp_engine_monitor.sv */
// Port checker of the stepper profile engine.
// Assumes the bind at the foot places it on every engine instance.
`timescale 1ns/10ps
module stp_engine_monitor (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic [7:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   input wire logic [stp_pkg::NUM_CH-1:0] step_o,
   input wire logic [stp_pkg::NUM_CH-1:0] dir_o,
   input wire logic irq_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rstn_i);
   a_wait_one_cycle: assert property (
      (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
      else $error("request not answered after one wait cycle");
   a_idle_no_wait: assert property (
      !(avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
      else $error("waitrequest high without a request");
   a_readdata_holds: assert property (
      !(avs_read_i && avs_waitrequest_o) |=> $stable(avs_readdata_o))
      else $error("read data changed without a read");
   a_step_gap_a: assert property (
      step_o[0] |=> !step_o[0] [*8])
      else $error("motor A steps faster than allowed");
   a_step_gap_b: assert property (
      step_o[1] |=> !step_o[1] [*8])
      else $error("motor B steps faster than allowed");
   a_reset_quiet: assert property (
      $rose(rstn_i) |-> step_o == 2'b00 && dir_o == 2'b00 && !irq_o)
      else $error("outputs not quiet after reset");
   a_irq_rise_cause: assert property (
      $rose(irq_o) |-> (|step_o) || $past(|step_o) || $past(|step_o, 2)
         || $past(|step_o, 3) || $past(avs_write_i) || $past(avs_write_i, 2)
         || $past(avs_write_i, 3) || $past(avs_write_i, 4))
      else $error("interrupt rose without a step or write");
   a_irq_fall_cause: assert property (
      $fell(irq_o) |-> $past(avs_write_i) || $past(avs_write_i, 2)
         || $past(avs_write_i, 3) || $past(avs_write_i, 4))
      else $error("interrupt fell without a write");
endmodule
bind stp_engine stp_engine_monitor i_mon (.clk_i(clk_i), .rstn_i(rstn_i),
   .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
   .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
   .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
   .step_o(step_o), .dir_o(dir_o), .irq_o(irq_o));

/* File: sim/stp_host_model.sv */
// Host model: issues commands over Avalon-MM and notes each expected read.
// Assumes the slave ends every wait by taking waitrequest low.
`timescale 1ns/10ps
module stp_host_model (
   input wire logic clk_i,
   input wire logic avs_waitrequest_i,
   input wire logic [31:0] avs_readdata_i,
   output logic [7:0] avs_address_o,
   output logic avs_read_o,
   output logic avs_write_o,
   output logic [31:0] avs_writedata_o,
   output logic [3:0] avs_byteenable_o
);
   import stp_pkg::*;
   logic [32:0] exp_q [$];
   initial begin
      avs_address_o = 8'h00;
      avs_read_o = 1'b0;
      avs_write_o = 1'b0;
      avs_writedata_o = 32'h0;
      avs_byteenable_o = 4'hf;
   end
   task automatic xfer(input logic r, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      avs_address_o <= a;
      avs_read_o <= r;
      avs_write_o <= !r;
      avs_writedata_o <= d;
      do @(posedge clk_i); while (avs_waitrequest_i);
      q = avs_readdata_i;
      avs_read_o <= 1'b0;
      avs_write_o <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b0, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a, input logic c, input logic [31:0] e,
                     output logic [31:0] q);
      exp_q.push_back({c, e});
      xfer(1'b1, a, 32'h0, q);
   endtask
   task automatic cmd(input logic [15:0] c, input logic [31:0] f0, input logic [31:0] f1,
                      input logic [31:0] f2, input logic [31:0] f3);
      logic [31:0] f [4];
      f = '{f0, f1, f2, f3};
      for (int k = 0; k < 4; k++) begin
         wr(8'(REG_PARAM0 + 8 * k), {16'h0, f[k][31:16]});
         wr(8'(REG_PARAM0 + 8 * k + 4), {16'h0, f[k][15:0]});
      end
      wr(REG_CMD, {16'h0, c});
   endtask
   // Clears raised flags, as the host must before a new move.
   task automatic ack(input logic [7:0] m);
      cmd(CMD_IRQ_ACK, {8'h0, m, 16'h0}, 32'h0, 32'h0, 32'h0);
   endtask
endmodule

/* File: sim/stp_engine_tb_top.sv */
// Self-checking bench of the stepper profile engine driven by the host model.
// Assumes the design package and a 200 MHz clock; the checker binds itself.
`timescale 1ns/10ps
module stp_engine_tb_top;
   import stp_pkg::*;
   localparam logic [31:0] FAST = 32'd50000;
   localparam logic [31:0] ACC = 32'd5000000;
   logic clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic [7:0] addr;
   logic rd_s, wr_s, wait_s, irq;
   logic [31:0] wdata, rdata, q, v;
   logic [3:0] be;
   logic [1:0] step, dir;
   logic [32:0] e;
   int error_cnt = 0;
   int tests_run = 0;
   int cyc = 0;
   int nstep [2] = '{0, 0};
   logic [31:0] rng [8][3] = '{'{14, 1000, 100000}, '{1001, 1000, 100000},
      '{100, 50001, 100000}, '{100, 1000, 49}, '{100, 1000, 5000001},
      '{100, 50000, 200000}, '{15, 50000, 5000000}, '{100, 1000, 50}};
   logic [15:0] rres [8] = '{RES_RANGE, RES_RANGE, RES_RANGE, RES_RANGE, RES_RANGE,
      RES_RAMP, RES_OK, RES_RAMP};
   logic [7:0] zregs [6] = '{REG_POS_A, REG_POS_B, REG_IRQ_STAT, REG_IRQ_MASK,
      REG_MOTION, 8'hfc};
   always #2.5 clk_i = ~clk_i;
   stp_engine i_dut (.clk_i(clk_i), .rstn_i(rstn_i), .avs_address_i(addr),
      .avs_read_i(rd_s), .avs_write_i(wr_s), .avs_writedata_i(wdata),
      .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_s),
      .step_o(step), .dir_o(dir), .irq_o(irq));
   stp_host_model i_host (.clk_i(clk_i), .avs_waitrequest_i(wait_s),
      .avs_readdata_i(rdata), .avs_address_o(addr), .avs_read_o(rd_s),
      .avs_write_o(wr_s), .avs_writedata_o(wdata), .avs_byteenable_o(be));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      if (error_cnt == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic wait_idle(input int ch);
      int n;
      n = 0;
      do begin
         i_host.rd(REG_MOTION, 1'b0, 32'h0, q);
         n++;
      end while (((q >> (3 * ch)) & 32'h3) != 0 && n < 20000);
   endtask
   task automatic wait_step(input int ch, input int n);
      while (nstep[ch] < n) @(posedge clk_i);
   endtask
   always @(posedge clk_i) begin
      cyc++;
      if (step[0]) nstep[0]++;
      if (step[1]) nstep[1]++;
      if (rd_s && !wait_s) begin
         e = i_host.exp_q.pop_front();
         if (e[32]) check(rdata, e[31:0]);
      end
      if (cyc == 100000) begin
         error_cnt++;
         end_of_test();
      end
   end
   initial begin
      void'($urandom(4605));
      repeat (5) @(posedge clk_i);
      rstn_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      foreach (zregs[i]) i_host.rd(zregs[i], 1'b1, 32'h0, q);
      for (int i = 0; i < 8; i++) begin
         i_host.cmd({CMD_ABS_MOVE, i[0]}, rng[i][0], rng[i][1], rng[i][2], 32'h0);
         i_host.rd(REG_RESULT, 1'b1, {16'h0, rres[i]}, q);
         i_host.rd(REG_MOTION, 1'b1, 32'h0, q);
      end
      i_host.rd(REG_IRQ_STAT, 1'b1, 32'h08, q);
      i_host.ack(8'h08);
      for (int ch = 0; ch < 2; ch++) begin
         v = $urandom;
         i_host.cmd({CMD_SET_POS, ch[0]}, v, 32'h0, 32'h0, 32'h0);
         i_host.cmd({CMD_GET_POS, ch[0]}, 32'h0, 32'h0, 32'h0, 32'h0);
         i_host.rd(REG_OUTPOS, 1'b1, v, q);
         i_host.rd(8'(REG_POS_A + 4 * ch), 1'b1, v, q);
      end
      for (int ch = 0; ch < 2; ch++) begin
         i_host.cmd({CMD_SET_POS, ch[0]}, 32'hffffffff, 32'h0, 32'h0, 32'h0);
         if (ch == 0) i_host.cmd({CMD_FIX_BRK, 1'b0}, 32'h1, 32'h0, 32'h0, 32'h0);
         else i_host.cmd({CMD_OFF_BRK, 1'b1}, 32'h2, 32'h0, 32'h0, 32'h0);
         i_host.cmd(CMD_MASK_IRQ, {8'h0, 8'(8'h02 << ch), 16'h0}, 32'h0, 32'h0, 32'h0);
         nstep = '{0, 0};
         if (ch == 0) i_host.cmd({CMD_ABS_MOVE, 1'b0}, FAST, FAST, ACC, 32'd2);
         else i_host.cmd({CMD_OFF_MOVE, 1'b1}, FAST, FAST, ACC, 32'd3);
         i_host.rd(REG_RESULT, 1'b1, 32'h0, q);
         check({31'h0, dir[ch]}, 32'h0);
         wait_idle(ch);
         check(32'(nstep[ch]), 32'd3);
         i_host.rd(8'(REG_POS_A + 4 * ch), 1'b1, 32'd2, q);
         i_host.rd(REG_IRQ_STAT, 1'b1, 32'h0a << ch, q);
         check({31'h0, irq}, 32'h1);
         i_host.ack(8'(8'h0a << ch));
         check({31'h0, irq}, 32'h0);
      end
      nstep = '{0, 0};
      i_host.cmd({CMD_ABS_MOVE, 1'b0}, FAST, FAST, ACC, 32'd1000);
      wait_step(0, 1);
      i_host.cmd({CMD_ABS_MOVE, 1'b0}, 32'd1000, 32'd1000, ACC, 32'd5);
      wait_idle(0);
      i_host.rd(REG_POS_A, 1'b1, 32'd5, q);
      i_host.ack(8'h08);
      nstep = '{0, 0};
      i_host.cmd({CMD_ABS_MOVE, 1'b0}, FAST, FAST, ACC, 32'd1000);
      wait_step(0, 1);
      i_host.cmd({CMD_ABS_MOVE, 1'b0}, FAST, FAST, ACC, 32'd0);
      wait_step(0, 2);
      check({31'h0, dir[0]}, 32'h1);
      i_host.cmd({CMD_ABORT, 1'b0}, 32'h0, 32'h0, 32'h0, 32'h0);
      wait_idle(0);
      i_host.rd(REG_POS_A, 1'b0, 32'h0, q);
      check({31'h0, q >= 32'd3 && q <= 32'd5}, 32'h1);
      end_of_test();
   end
endmodule
